// ==== emasr_regs.sv ====
// Purpose: Energy meter, alert mask and snapshot control register bank
// Assumes: Register port from the serial interface decoder on clk
// Notes:   Multi-byte values are not shadowed; host halts first for coherence
`default_nettype none

module emasr_regs
    import emasr_pkg::*;
#(
    parameter int PW = POWER_W
)(
    input  wire logic          clk,            // 100 MHz system clock
    input  wire logic          nrst,           // Synchronous reset, active low
    input  wire logic          ce,             // Clock enable, freezes all state
    input  wire logic [7:0]    reg_addr,       // Register byte address
    input  wire logic          reg_wr,         // Write strobe
    input  wire logic          reg_rd,         // Read strobe
    input  wire logic [7:0]    reg_wdata,      // Write data
    output logic      [7:0]    reg_rdata,      // Read data, valid cycle after reg_rd
    input  wire logic          conv_done,      // Conversion cycle done pulse
    input  wire logic [PW-1:0] conv_power,     // Power result of that cycle
    input  wire logic [15:0]   alarm_log,      // Alarm flags, drain/shunt high byte
    input  wire logic          ovf_alert_en_tick,   // Config mask for tick wrap
    input  wire logic          ovf_alert_en_energy, // Config mask for energy wrap
    input  wire logic          other_alert,    // Alert event from other sources
    input  wire logic          nvm_factory_lock, // Memory lock pin
    output logic               alert_evt_out,  // Alert generated pulse
    output logic               snap_mode,      // Converter in snapshot mode
    output logic      [3:0]    snap_sel,       // Selected snapshot input
    output logic               snap_start      // Start single conversion pulse
);
    logic [7:0]          mask_ds;
    logic [7:0]          mask_dp;
    logic [ENERGY_W-1:0] energy;
    logic [TICK_W-1:0]   ticks;
    logic                clr_bit;
    logic                halt_bit;
    logic                tick_ovf;
    logic                energy_ovf;
    logic                alert_seen;
    logic [1:0]          lock_sync;
    logic                mask_evt;
    logic                accum;
    logic [ENERGY_W:0]   next_energy;
    logic [TICK_W:0]     next_ticks;
    logic                ovf_evt;
    emasr_conv_e         conv_state;

    if (PW < 1 || PW > ENERGY_W)
    begin : g_bad_pw
        $error("PW out of range");
    end

    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic host_wr(input logic [7:0] a);
        host_wr = reg_wr && (reg_addr == a);
    endfunction

    assign accum       = conv_done && !halt_bit && !clr_bit;                              // [RULE6] [RULE5]
    assign next_energy = {1'b0, energy} + {{(ENERGY_W + 1 - PW){1'b0}}, conv_power};
    assign next_ticks  = {1'b0, ticks} + {{TICK_W{1'b0}}, 1'b1};
    assign ovf_evt     = accum && ((next_ticks[TICK_W] && ovf_alert_en_tick)
                         || (next_energy[ENERGY_W] && ovf_alert_en_energy));

    emasr_alert_gate #(.N(16)) u_gate (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .alarm     (alarm_log),
        .mask      ({mask_ds, mask_dp}),
        .alert_evt (mask_evt)
    );

    // Alert masks
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            mask_ds <= MASK_RESET;
            mask_dp <= MASK_RESET;
        end
        else if (ce)
        begin
            if (host_wr(ADDR_MASK_DRAIN_SHUNT))
                mask_ds <= reg_wdata; // [RULE1]
            if (host_wr(ADDR_MASK_DIFF_PAIRS))
                mask_dp <= reg_wdata; // [RULE2]
        end
    end

    // Energy accumulator: clear wins, then host byte writes, then accumulation
    always_ff @(posedge clk)
    begin
        if (!nrst)
            energy <= '0; // [RULE3]
        else if (ce)
        begin
            if (clr_bit)
                energy <= '0; // [RULE5]
            else if (reg_wr && in_range(reg_addr, ADDR_ENERGY_LO, ADDR_ENERGY_HI))
            begin
                for (int i = 0; i < ENERGY_W / 8; i++)
                    if (reg_addr == ADDR_ENERGY_LO + 8'(i))
                        energy[8*i +: 8] <= reg_wdata; // [RULE3]
            end
            else if (accum)
                energy <= next_energy[ENERGY_W-1:0];
        end
    end

    // Tick counter
    always_ff @(posedge clk)
    begin
        if (!nrst)
            ticks <= '0;
        else if (ce)
        begin
            if (clr_bit)
                ticks <= '0; // [RULE5]
            else if (reg_wr && in_range(reg_addr, ADDR_TICK_LO, ADDR_TICK_HI))
            begin
                for (int i = 0; i < TICK_W / 8; i++)
                    if (reg_addr == ADDR_TICK_LO + 8'(i))
                        ticks[8*i +: 8] <= reg_wdata;
            end
            else if (accum)
                ticks <= next_ticks[TICK_W-1:0]; // [RULE4]
        end
    end

    // Meter control and status; hardware set wins over host clear
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            clr_bit    <= 1'b0;
            halt_bit   <= 1'b0;
            tick_ovf   <= 1'b0;
            energy_ovf <= 1'b0;
            alert_seen <= 1'b0;
        end
        else if (ce)
        begin
            if (host_wr(ADDR_METER_CTRL))
            begin
                clr_bit    <= reg_wdata[BIT_CLEAR];
                halt_bit   <= reg_wdata[BIT_HALT];
                tick_ovf   <= reg_wdata[BIT_TICK_OVF];
                energy_ovf <= reg_wdata[BIT_ENERGY_OVF];
                alert_seen <= reg_wdata[BIT_ALERT_SEEN]; // [RULE9]
            end
            if (accum && next_ticks[TICK_W])
                tick_ovf <= 1'b1; // [RULE7]
            if (accum && next_energy[ENERGY_W])
                energy_ovf <= 1'b1; // [RULE8]
            if (alert_evt_out)
                alert_seen <= 1'b1; // [RULE9]
        end
    end

    // Lock pin comes from outside the clock domain
    always_ff @(posedge clk)
    begin
        if (!nrst)
            lock_sync <= 2'b00;
        else if (ce)
            lock_sync <= {lock_sync[0], nvm_factory_lock};
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            alert_evt_out <= 1'b0;
        else if (ce)
            alert_evt_out <= mask_evt || other_alert || ovf_evt;
    end

    // Snapshot control: one conversion per host write while in snapshot mode
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            snap_mode  <= 1'b0;
            snap_sel   <= 4'h0;
            snap_start <= 1'b0;
            conv_state <= EMASR_CONT;
        end
        else if (ce)
        begin
            snap_start <= 1'b0;
            if (host_wr(ADDR_SNAPSHOT))
            begin
                snap_sel  <= reg_wdata[SEL_MSB:SEL_LSB];   // [RULE12]
                snap_mode <= reg_wdata[BIT_SNAP_MODE];      // [RULE13]
                conv_state <= reg_wdata[BIT_SNAP_MODE] ? EMASR_SNAP_REQ : EMASR_CONT;
            end
            else
            begin
                case (conv_state)
                    EMASR_SNAP_REQ:
                    begin
                        snap_start <= 1'b1; // [RULE15]
                        conv_state <= EMASR_SNAP_IDLE;
                    end
                    default:
                        conv_state <= conv_state;
                endcase
            end
        end
    end

    // Read data registered one cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (!nrst)
            reg_rdata <= ZERO_BYTE;
        else if (ce && reg_rd)
        begin
            if (reg_addr == ADDR_MASK_DRAIN_SHUNT)
                reg_rdata <= mask_ds;
            else if (reg_addr == ADDR_MASK_DIFF_PAIRS)
                reg_rdata <= mask_dp;
            else if (in_range(reg_addr, ADDR_ENERGY_LO, ADDR_ENERGY_HI))
                reg_rdata <= energy[8*(reg_addr - ADDR_ENERGY_LO) +: 8];
            else if (in_range(reg_addr, ADDR_TICK_LO, ADDR_TICK_HI))
                reg_rdata <= ticks[8*(reg_addr - ADDR_TICK_LO) +: 8];
            else if (reg_addr == ADDR_METER_CTRL)
                reg_rdata <= {clr_bit, halt_bit, tick_ovf, energy_ovf, alert_seen,
                              lock_sync[1], 2'b00}; // [RULE10] [RULE11]
            else if (reg_addr == ADDR_SNAPSHOT)
                reg_rdata <= {snap_sel, snap_mode, 3'b000}; // [RULE11]
            else
                reg_rdata <= ZERO_BYTE;
        end
    end
endmodule : emasr_regs

`default_nettype wire

// ==== emasr_pkg.sv ====
// Purpose: Constants for the energy meter, alert mask and snapshot register bank
// Assumes: Byte-wide register port, one byte address per register byte
// Notes:   Offsets are byte addresses of the device register map
//
// What this block does
// [RULE1] Mask register enables drain and shunt threshold alerts
// [RULE2] Mask register enables differential pair threshold alerts
// [RULE3] 48-bit energy accumulator, host read/write, reset zero
// [RULE4] Tick counter counts each accumulated conversion cycle
// [RULE5] Clear bit holds accumulator and ticks at zero
// [RULE6] Halt bit freezes accumulator and tick counter
// [RULE7] Sticky flag when tick counter wraps
// [RULE8] Sticky flag when energy accumulator wraps
// [RULE9] Alert flag latched by hardware, host writes it to either value
// [RULE10] Read-only status shows memory factory lock
// [RULE11] Unused low control and snapshot bits read zero
// [RULE12] Four-bit field selects one of sixteen inputs
// [RULE13] Converter halt bit chooses snapshot or continuous mode
// [RULE14] Mask bits gate matching alarm log flags
// [RULE15] Snapshot converts once, then idles until rewritten
// [RULE16] Host halts before reading multi-byte values
`default_nettype none

package emasr_pkg;
    localparam logic [7:0] ADDR_MASK_DRAIN_SHUNT = 8'h19;
    localparam logic [7:0] ADDR_MASK_DIFF_PAIRS  = 8'h1A;
    localparam logic [7:0] ADDR_ENERGY_LO        = 8'h7A;
    localparam logic [7:0] ADDR_ENERGY_HI        = 8'h7F;
    localparam logic [7:0] ADDR_TICK_LO          = 8'h80;
    localparam logic [7:0] ADDR_TICK_HI          = 8'h83;
    localparam logic [7:0] ADDR_METER_CTRL       = 8'h84;
    localparam logic [7:0] ADDR_SNAPSHOT         = 8'h85;

    localparam int ENERGY_W = 48;
    localparam int TICK_W   = 32;
    localparam int POWER_W  = 24;

    localparam int BIT_CLEAR      = 7;
    localparam int BIT_HALT       = 6;
    localparam int BIT_TICK_OVF   = 5;
    localparam int BIT_ENERGY_OVF = 4;
    localparam int BIT_ALERT_SEEN = 3;
    localparam int BIT_NVM_LOCK   = 2;
    localparam int BIT_SNAP_MODE  = 3;
    localparam int SEL_MSB        = 7;
    localparam int SEL_LSB        = 4;

    localparam logic [7:0] MASK_RESET     = 8'h00;
    localparam logic [7:0] CTRL_WR_MASK   = 8'hF8;
    localparam logic [7:0] SNAP_WR_MASK   = 8'hF8;
    localparam logic [7:0] ZERO_BYTE      = 8'h00;

    typedef enum logic [1:0] {EMASR_CONT, EMASR_SNAP_REQ, EMASR_SNAP_IDLE} emasr_conv_e;
endpackage : emasr_pkg

`default_nettype wire

// ==== emasr_alert_gate.sv ====
// Purpose: Gates alarm log flags with alert masks, reports any alert event
// Assumes: Alarm flags and masks on the same clock
// Notes:   Output is registered so the event is one clean pulse per rise
`default_nettype none

module emasr_alert_gate
    import emasr_pkg::*;
#(
    parameter int N = 16
)(
    input  wire logic         clk,       // System clock
    input  wire logic         nrst,      // Synchronous reset, active low
    input  wire logic         ce,        // Clock enable
    input  wire logic [N-1:0] alarm,     // Alarm log flags
    input  wire logic [N-1:0] mask,      // Alert enables
    output logic              alert_evt  // One-cycle pulse on new gated alarm
);
    logic [N-1:0] gated;
    logic [N-1:0] gated_q;

    if (N < 1)
    begin : g_bad_n
        $error("N must be at least 1");
    end

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_gate
            assign gated[g] = alarm[g] & mask[g]; // [RULE14]
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            gated_q   <= '0;
            alert_evt <= 1'b0;
        end
        else if (ce)
        begin
            gated_q   <= gated;
            alert_evt <= |(gated & ~gated_q);
        end
    end
endmodule : emasr_alert_gate

`default_nettype wire

// ==== emasr_conv_model.sv ====
// Purpose: Converter side model feeding conversion results to the bank
// Assumes: Snapshot result comes a few cycles after each start pulse
// Notes:   Free-run period is long so register traffic rarely meets a pulse
`default_nettype none
module emasr_conv_model (
    input  wire logic        clk,                 // Clock
    input  wire logic        snap_mode,           // Snapshot mode
    input  wire logic        snap_start,          // Snapshot start
    output var  logic        conv_done = 1'b0,    // Conversion done
    output var  logic [23:0] conv_power = 24'h0   // Power result
);
    timeunit 1ns;
    timeprecision 1ps;
    int         cnt = 1;
    logic [2:0] dly = 3'h0;
    always @(posedge clk)
    begin
        cnt <= (cnt + 1) % 40;
        dly <= {dly[1:0], snap_start};
        conv_done <= snap_mode ? dly[2] : (cnt == 0);
        conv_power <= 24'($urandom);
    end
endmodule // emasr_conv_model
`default_nettype wire

// ==== emasr_regs_chk.sv ====
// Purpose: Port timing checks for the register bank
// Assumes: Host requests spaced two cycles apart
// Notes:   Lock check waits out the pin synchroniser
`default_nettype none
module emasr_regs_chk
    import emasr_pkg::*;
(
    input wire logic       clk,              // Clock
    input wire logic       nrst,             // Reset
    input wire logic       ce,               // Enable
    input wire logic [7:0] reg_addr,         // Address
    input wire logic       reg_wr,           // Write
    input wire logic       reg_rd,           // Read
    input wire logic [7:0] reg_wdata,        // Write data
    input wire logic [7:0] reg_rdata,        // Read data
    input wire logic       nvm_factory_lock, // Lock pin
    input wire logic       alert_evt_out,    // Alert pulse
    input wire logic       snap_mode,        // Snapshot mode
    input wire logic [3:0] snap_sel,         // Snapshot input
    input wire logic       snap_start        // Snapshot start
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire rd84 = ce && reg_rd && reg_addr == ADDR_METER_CTRL;
    wire wr84 = ce && reg_wr && reg_addr == ADDR_METER_CTRL;
    wire rd85 = ce && reg_rd && reg_addr == ADDR_SNAPSHOT;
    wire wr85 = ce && reg_wr && reg_addr == ADDR_SNAPSHOT;
    logic alert_hold;
    // Expected alert flag: set by any alert, changed otherwise only by a host write
    always_ff @(posedge clk)
    begin
        if (!nrst)
            alert_hold <= 1'b0;
        else if (ce)
        begin
            if (alert_evt_out)
                alert_hold <= 1'b1;
            else if (wr84)
                alert_hold <= reg_wdata[BIT_ALERT_SEEN];
        end
    end
    sequence s_snap_wr;
        wr85 && reg_wdata[BIT_SNAP_MODE];
    endsequence
    sequence s_snap_go;
        snap_mode ##1 snap_start ##1 !snap_start;
    endsequence
    property p_ctrl_rsvd; rd84 |=> reg_rdata[1:0] == 2'h0; endproperty
    property p_snap_rsvd; rd85 |=> reg_rdata[2:0] == 3'h0; endproperty
    property p_snap_sel; wr85 |=> snap_sel == $past(reg_wdata[7:4]) && snap_mode == $past(reg_wdata[3]); endproperty
    property p_snap_go; s_snap_wr ##1 !wr85 |-> s_snap_go; endproperty
    property p_start_mode; snap_start |-> snap_mode; endproperty
    property p_cont; wr85 && !reg_wdata[3] |=> !snap_mode ##1 !snap_start ##1 (!snap_start || $past(wr85, 2)); endproperty
    property p_lock;
        $stable(nvm_factory_lock) [*3] ##0 rd84 && $past(nrst) && $past(nrst, 2)
        |=> reg_rdata[2] == $past(nvm_factory_lock);
    endproperty
    property p_alert; rd84 && alert_hold |=> reg_rdata[BIT_ALERT_SEEN]; endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd)
        else $error("control low bits not zero");
    a_snap_rsvd: assert property (p_snap_rsvd)
        else $error("snapshot low bits not zero");
    a_snap_sel: assert property (p_snap_sel)
        else $error("snapshot select not taken");
    a_snap_go: assert property (p_snap_go)
        else $error("snapshot start pulse wrong");
    a_start_mode: assert property (p_start_mode)
        else $error("start outside snapshot mode");
    a_cont: assert property (p_cont)
        else $error("continuous mode not resumed");
    a_lock: assert property (p_lock)
        else $error("lock status wrong");
    a_alert: assert property (p_alert)
        else $error("alert flag not latched");
endmodule // emasr_regs_chk
bind emasr_regs emasr_regs_chk i_chk (.clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .nvm_factory_lock(nvm_factory_lock),
    .alert_evt_out(alert_evt_out), .snap_mode(snap_mode), .snap_sel(snap_sel), .snap_start(snap_start));
`default_nettype wire

// ==== emasr_regs_test.sv ====
// Purpose: Self-checking bench for the meter register bank
// Assumes: ce high except for one 100-cycle low window; converter model drives conversions
// Notes:   Energy and ticks are mirrored from host writes and conversions
`default_nettype none
module emasr_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import emasr_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, d, v;
    logic [15:0] alarm = 16'h0000;
    logic        oae = 1'b0, oat = 1'b0, oth = 1'b0, lock = 1'b0;
    logic        done, evt, smode, sstart, hq, cq, fe, ft, c, run;
    logic [23:0] pwr;
    logic [3:0]  ssel;
    logic [47:0] xe;
    logic [31:0] xt;
    int          error_cnt = 0, comparisons = 0, bi;
    always #5 clk = ~clk;
    emasr_regs i_dut (.clk(clk), .nrst(nrst), .ce(ce), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdata), .reg_rdata(rdata), .conv_done(done), .conv_power(pwr), .alarm_log(alarm),
        .ovf_alert_en_tick(oat), .ovf_alert_en_energy(oae), .other_alert(oth), .nvm_factory_lock(lock),
        .alert_evt_out(evt), .snap_mode(smode), .snap_sel(ssel), .snap_start(sstart));
    emasr_conv_model i_conv (.clk(clk), .snap_mode(smode), .snap_start(sstart), .conv_done(done), .conv_power(pwr));
    // Mirror uses the old halt and clear values, as the bank does
    always @(posedge clk)
    begin
        run = done && !hq && !cq;
        bi = int'(addr) - int'(ADDR_ENERGY_LO);
        if (!nrst)
            {xe, xt, hq, cq, fe, ft} = '0;
        else if (ce)
        begin
            if (cq)
                {xe, xt} = '0;
            if (wr && !cq && bi >= 0 && bi < 6)
                xe[8*bi+:8] = wdata;
            if (wr && !cq && bi >= 6 && bi < 10)
                xt[8*(bi-6)+:8] = wdata;
            if (wr && addr == ADDR_METER_CTRL)
                {cq, hq, ft, fe} = wdata[7:4];
            if (run)
            begin
                {c, xe} = xe + pwr;
                fe |= c;
                {c, xt} = xt + 1;
                ft |= c;
            end
        end
    end
    task automatic close_out;
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] val);
        @(posedge clk);
        #1;
        {wr, rd, addr, wdata} = {w, !w, a, val};
        @(posedge clk);
        #1;
        {wr, rd} = 2'b00;
        d = rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        cmp(d, exp);
    endtask
    task automatic chk_bank;
        for (int i = 0; i < 10; i++)
            rdc(ADDR_ENERGY_LO + 8'(i), 8'({xt, xe} >> (8 * i)));
    endtask
    task automatic rise(input int b, input logic e);
        logic hit;
        hit = 1'b0;
        @(posedge clk);
        #1;
        if (b < 16) alarm[b] = 1'b1; else oth = 1'b1;
        repeat (6)
        begin
            @(posedge clk);
            #1;
            oth = 1'b0;
            hit |= evt;
        end
        cmp({7'h0, hit}, {7'h0, e});
    endtask
    initial
    begin
        #200us;
        error_cnt++;
        close_out();
    end
    initial
    begin
        void'($urandom(32'h9560));
        repeat (4) @(posedge clk);
        #1;
        nrst = 1'b1;
        rdc(ADDR_MASK_DRAIN_SHUNT, MASK_RESET);
        rdc(ADDR_MASK_DIFF_PAIRS, MASK_RESET);
        rdc(ADDR_METER_CTRL, 8'h00);
        rdc(ADDR_SNAPSHOT, 8'h00);
        bus(1'b1, ADDR_METER_CTRL, 8'h40);
        chk_bank();
        for (int k = 0; k < 12; k++)
        begin
            v = 8'($urandom);
            bus(1'b1, k < 2 ? ADDR_MASK_DRAIN_SHUNT + 8'(k) : ADDR_ENERGY_LO + 8'(k - 2), v);
            rdc(addr, v);
        end
        repeat (100) @(posedge clk);
        chk_bank();
        bus(1'b1, ADDR_METER_CTRL, 8'h00);
        repeat (200) @(posedge clk);
        bus(1'b1, ADDR_METER_CTRL, 8'h40);
        chk_bank();
        // Conversions that land while the enable is low must be lost
        bus(1'b1, ADDR_METER_CTRL, 8'h00);
        ce = 1'b0;
        repeat (100) @(posedge clk);
        #1;
        ce = 1'b1;
        bus(1'b1, ADDR_METER_CTRL, 8'h40);
        chk_bank();
        for (int i = 0; i < 10; i++)
            bus(1'b1, ADDR_ENERGY_LO + 8'(i), 8'hFF);
        {oat, oae} = 2'b11;
        bus(1'b1, ADDR_SNAPSHOT, 8'h48);
        repeat (10) @(posedge clk);
        bus(1'b1, ADDR_METER_CTRL, 8'h00);
        bus(1'b1, ADDR_SNAPSHOT, 8'h98);
        repeat (10) @(posedge clk);
        rdc(ADDR_METER_CTRL, {2'b00, ft, fe, ft | fe, 3'b000});
        bus(1'b1, ADDR_METER_CTRL, 8'h40);
        chk_bank();
        bus(1'b1, ADDR_METER_CTRL, 8'hFF);
        rdc(ADDR_METER_CTRL, 8'hF8);
        bus(1'b1, ADDR_ENERGY_LO, 8'h5A);
        chk_bank();
        bus(1'b1, ADDR_METER_CTRL, 8'h00);
        bus(1'b1, ADDR_SNAPSHOT, 8'h18);
        repeat (10) @(posedge clk);
        bus(1'b1, ADDR_METER_CTRL, 8'h40);
        chk_bank();
        for (int s = 0; s < 16; s++)
        begin
            v = {4'(s), 1'b1, 3'($urandom)};
            bus(1'b1, ADDR_SNAPSHOT, v);
            cmp({4'h0, ssel}, 8'(s));
            rdc(ADDR_SNAPSHOT, v & SNAP_WR_MASK);
        end
        bus(1'b1, ADDR_SNAPSHOT, 8'h50);
        cmp({7'h0, smode}, 8'h00);
        lock = 1'b1;
        bus(1'b1, ADDR_METER_CTRL, 8'h40);
        rdc(ADDR_METER_CTRL, 8'h44);
        lock = 1'b0;
        bus(1'b1, ADDR_MASK_DRAIN_SHUNT, 8'h80);
        bus(1'b1, ADDR_MASK_DIFF_PAIRS, 8'h01);
        bus(1'b1, ADDR_METER_CTRL, 8'h40);
        rise(15, 1'b1);
        repeat (20) @(posedge clk);
        rdc(ADDR_METER_CTRL, 8'h48);
        bus(1'b1, ADDR_METER_CTRL, 8'h40);
        rdc(ADDR_METER_CTRL, 8'h40);
        rise(14, 1'b0);
        rise(0, 1'b1);
        rise(16, 1'b1);
        close_out();
    end
endmodule // emasr_regs_test
`default_nettype wire
